// ### logic/aer_defs.vh
// Offsets, field positions, reset values of the uncorrectable mask/severity block
`ifndef AER_DEFS_VH
`define AER_DEFS_VH
`define MASK_OFFSET 12'h108
`define SEV_OFFSET 12'h10c
`define STATUS_OFFSET 12'h104
`define CTRL_OFFSET 12'h120
`define INT_STATUS_OFFSET 12'h200
`define INT_MASK_OFFSET 12'h204
`define MASK_IE_POS 22
`define MASK_MC_POS 23
`define MASK_IE_RST 1'b1
`define MASK_MC_RST 1'b0
`define SEV_UNUSED_POS 0
`define SEV_DLP_POS 4
`define SEV_SDN_POS 5
`define SEV_POIS_POS 12
`define SEV_FCP_POS 13
`define SEV_IMPL 32'h0000_3031
`define SEV_RST 32'h0000_2030
`define SEV_IMPL_NOEFFECT 32'h0000_0001
`define MASK_IMPL 32'h00c0_0000
`define CTRL_IE_EN_POS 0
`define CTRL_MC_DIS_POS 1
`define CTRL_RST 2'h1
`define EVT_LOGGED_POS 0
`define EVT_FATAL_POS 1
`define EVT_NONFATAL_POS 2
`endif

// ### logic/sync3.v
// Three-stage synchroniser with agreement filter
`timescale 1ns/1ps
module sync3 (
    // Clock and reset
    input wire clk,
    input wire rst_n,
    // Data
    input wire d,
    output reg q
);
    reg s1_reg;
    reg s2_reg;
    reg s3_reg;
    always @(posedge clk) begin
        if (!rst_n) begin
            s1_reg <= 1'b0;
            s2_reg <= 1'b0;
            s3_reg <= 1'b0;
            q <= 1'b0;
        end else begin
            s1_reg <= d;
            s2_reg <= s1_reg;
            s3_reg <= s2_reg;
            if (s2_reg == s3_reg) begin
                q <= s3_reg;
            end
        end
    end
endmodule // sync3

// ### logic/aer_uncorr_mask_sev.v
// Uncorrectable error mask (bits 22-23) and severity (bits 0-13) registers
//
// Operation
// - Internal error mask bit 22, default one
// - Masked errors: no log, pointer, report
// - Masking never alters status bits
// - Internal mask reads zero when reporting disabled
// - Multicast blocked mask bit 23, default zero
// - Multicast mask reads zero when disabled
// - Severity register at offset 0x10c
// - Severity one fatal, zero non-fatal
// - Severity bit 0 writable, no effect
// - Link protocol severity bit 4, default one
// - Surprise down severity bit 5, default one
// - Poisoned severity bit 12, default zero
// - Flow control severity bit 13, default one
//
// The implementer's own choice: the AHB-Lite slave port.
`timescale 1ns/1ps
`include "aer_defs.vh"
module aer_uncorr_mask_sev (
    // Clock and resets
    input wire clk,
    input wire rst_n,
    input wire hot_rst_n,
    // AHB-Lite slave
    input wire hsel,
    input wire [11:0] haddr,
    input wire [1:0] htrans,
    input wire hwrite,
    input wire [2:0] hsize,
    input wire [31:0] hwdata,
    input wire hready,
    output reg [31:0] hrdata,
    output reg hreadyout,
    output reg hresp,
    // Error events from the port
    input wire [31:0] err_event,
    // Report toward root complex
    output reg log_strobe,
    output reg [4:0] first_err_ptr,
    output reg report_fatal,
    output reg report_nonfatal,
    output reg irq
);
    reg [31:0] status_reg;
    reg [31:0] mask_reg;
    reg [31:0] sev_reg;
    reg [1:0] ctrl_reg;
    reg [2:0] int_status_reg;
    reg [2:0] int_mask_reg;
    reg ptr_valid_reg;
    reg wr_pend_reg;
    reg [11:0] wr_addr_reg;
    reg [31:0] eff_mask;
    reg [31:0] unmasked;
    reg [4:0] ptr_next;
    reg found;
    reg [2:0] evt;
    reg [31:0] rd_next;
    wire [31:0] ev_sync;
    wire ie_en;
    wire mc_dis;
    wire wr_now;
    wire accept;
    wire sync_rst_n;
    wire wr_mask;
    wire wr_sev;
    wire wr_status;
    wire wr_ctrl;
    wire wr_int_status;
    wire wr_int_mask;
    wire [31:0] ptr_onehot;
    wire ptr_clear;
    integer i;

    // One synchroniser per error event line
    genvar g;
    generate
        for (g = 0; g < 32; g = g + 1) begin : g_sync
            sync3 u_sync (
                .clk(clk),
                .rst_n(sync_rst_n),
                .d(err_event[g]),
                .q(ev_sync[g])
            );
        end
    endgenerate

    assign ie_en = ctrl_reg[`CTRL_IE_EN_POS];
    assign mc_dis = ctrl_reg[`CTRL_MC_DIS_POS];
    assign wr_now = wr_pend_reg;
    // Either reset empties the synchronisers
    assign sync_rst_n = rst_n && hot_rst_n;
    // Transfer accepted in its address phase
    assign accept = hsel && hready && htrans[1];

    // Write strobes, one per register, valid in the data phase
    assign wr_mask = wr_now && (wr_addr_reg == `MASK_OFFSET);
    assign wr_sev = wr_now && (wr_addr_reg == `SEV_OFFSET);
    assign wr_status = wr_now && (wr_addr_reg == `STATUS_OFFSET);
    assign wr_ctrl = wr_now && (wr_addr_reg == `CTRL_OFFSET);
    assign wr_int_status = wr_now && (wr_addr_reg == `INT_STATUS_OFFSET);
    assign wr_int_mask = wr_now && (wr_addr_reg == `INT_MASK_OFFSET);

    // Status bit under the held pointer being cleared
    assign ptr_onehot = 32'h0000_0001 << first_err_ptr;
    assign ptr_clear = wr_status && |(status_reg & hwdata & ptr_onehot);

    // Effective masks and first-error search
    always @* begin
        eff_mask = mask_reg & `MASK_IMPL;
        if (!ie_en) begin
            eff_mask[`MASK_IE_POS] = 1'b0;
        end
        if (mc_dis) begin
            eff_mask[`MASK_MC_POS] = 1'b0;
        end
        unmasked = ev_sync & ~status_reg & ~eff_mask;
        ptr_next = 5'h00;
        found = 1'b0;
        // Lowest-numbered new error wins the pointer
        for (i = 31; i >= 0; i = i - 1) begin
            if (unmasked[i]) begin
                ptr_next = i[4:0];
                found = 1'b1;
            end
        end
        evt[`EVT_LOGGED_POS] = found;
        evt[`EVT_FATAL_POS] = |(unmasked & sev_reg & ~`SEV_IMPL_NOEFFECT);
        evt[`EVT_NONFATAL_POS] = |(unmasked & ~sev_reg & ~`SEV_IMPL_NOEFFECT);
    end

    // Read mux
    always @* begin
        rd_next = 32'h0000_0000;
        if (haddr == `MASK_OFFSET) begin
            rd_next = eff_mask;
        end else if (haddr == `SEV_OFFSET) begin
            rd_next = sev_reg & `SEV_IMPL;
        end else if (haddr == `STATUS_OFFSET) begin
            // Status shows every captured error
            rd_next = status_reg;
        end else if (haddr == `CTRL_OFFSET) begin
            // Control, non-sticky
            rd_next = {30'h0, ctrl_reg};
        end else if (haddr == `INT_STATUS_OFFSET) begin
            // Event status, write one to clear
            rd_next = {29'h0, int_status_reg};
        end else if (haddr == `INT_MASK_OFFSET) begin
            // Event enables for irq
            rd_next = {29'h0, int_mask_reg};
        end
    end

    // Bus response: zero wait states, always OKAY
    always @(posedge clk) begin
        if (!rst_n) begin
            hreadyout <= 1'b1;
            hresp <= 1'b0;
        end else begin
            hreadyout <= 1'b1;
            hresp <= 1'b0;
        end
    end

    // Address phase capture; read data stands for the data phase
    always @(posedge clk) begin
        if (!rst_n) begin
            hrdata <= 32'h0000_0000;
            wr_pend_reg <= 1'b0;
            wr_addr_reg <= 12'h000;
        end else begin
            wr_pend_reg <= 1'b0;
            if (accept) begin
                wr_pend_reg <= hwrite;
                wr_addr_reg <= haddr;
                if (!hwrite) begin
                    hrdata <= rd_next;
                end
            end
        end
    end

    always @(posedge clk) begin
        if (!rst_n) begin
            mask_reg <= 32'h0000_0000;
            mask_reg[`MASK_IE_POS] <= `MASK_IE_RST;
            mask_reg[`MASK_MC_POS] <= `MASK_MC_RST;
        end else if (wr_mask) begin
            if (ie_en) begin
                mask_reg[`MASK_IE_POS] <= hwdata[`MASK_IE_POS];
            end
            if (!mc_dis) begin
                mask_reg[`MASK_MC_POS] <= hwdata[`MASK_MC_POS];
            end
        end
    end

    always @(posedge clk) begin
        if (!rst_n) begin
            sev_reg <= `SEV_RST;
        end else if (wr_sev) begin
            sev_reg <= hwdata & `SEV_IMPL;
        end
    end

    // Control register, loaded with 1 (internal reporting on) by either reset
    // Bit 0 enables internal reporting, bit 1 disables multicast
    always @(posedge clk) begin
        if (!rst_n || !hot_rst_n) begin
            ctrl_reg <= `CTRL_RST;
        end else if (wr_ctrl) begin
            ctrl_reg <= hwdata[1:0];
        end
    end

    // Interrupt mask register
    // Bit 0 logged, bit 1 fatal, bit 2 non-fatal
    always @(posedge clk) begin
        if (!rst_n || !hot_rst_n) begin
            int_mask_reg <= 3'h0;
        end else if (wr_int_mask) begin
            int_mask_reg <= hwdata[2:0];
        end
    end

    always @(posedge clk) begin
        if (!rst_n || !hot_rst_n) begin
            status_reg <= 32'h0000_0000;
        end else if (wr_status) begin
            // Set wins over a clear in the same cycle
            status_reg <= (status_reg & ~hwdata) | ev_sync;
        end else begin
            status_reg <= status_reg | ev_sync;
        end
    end

    // pointer held until its bit clears
    always @(posedge clk) begin
        if (!rst_n || !hot_rst_n) begin
            ptr_valid_reg <= 1'b0;
            first_err_ptr <= 5'h00;
        end else begin
            // A clear of the pointed bit frees the pointer
            if (ptr_clear) begin
                ptr_valid_reg <= 1'b0;
            end
            // Only an unmasked new error is taken
            if (found && !ptr_valid_reg) begin
                first_err_ptr <= ptr_next;
                ptr_valid_reg <= 1'b1;
            end
        end
    end

    // masked errors neither logged nor reported
    always @(posedge clk) begin
        if (!rst_n || !hot_rst_n) begin
            log_strobe <= 1'b0;
            report_fatal <= 1'b0;
            report_nonfatal <= 1'b0;
        end else begin
            // One-cycle pulses, one cycle after detection
            log_strobe <= evt[`EVT_LOGGED_POS];
            report_fatal <= evt[`EVT_FATAL_POS];
            report_nonfatal <= evt[`EVT_NONFATAL_POS];
        end
    end

    // Interrupt status, write one to clear, set wins
    always @(posedge clk) begin
        if (!rst_n || !hot_rst_n) begin
            int_status_reg <= 3'h0;
        end else if (wr_int_status) begin
            int_status_reg <= (int_status_reg & ~hwdata[2:0]) | evt;
        end else begin
            int_status_reg <= int_status_reg | evt;
        end
    end

    // Level interrupt, registered so it comes from a flop
    always @(posedge clk) begin
        if (!rst_n || !hot_rst_n) begin
            irq <= 1'b0;
        end else begin
            irq <= |(int_status_reg & int_mask_reg);
        end
    end
endmodule // aer_uncorr_mask_sev

// ### dv/aer_props.sv
// Port assertions for the uncorrectable mask and severity block
`timescale 1ns/1ps
module aer_props (
    // Clock and resets
    input wire clk,
    input wire rst_n,
    input wire hot_rst_n,
    // Bus
    input wire hsel,
    input wire [1:0] htrans,
    input wire hwrite,
    input wire hready,
    input wire [31:0] hrdata,
    input wire hreadyout,
    input wire hresp,
    // Events and reports
    input wire [31:0] err_event,
    input wire log_strobe,
    input wire [4:0] first_err_ptr,
    input wire report_fatal,
    input wire report_nonfatal,
    input wire irq
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);
    bus_ready_a: assert property (hreadyout)
        else $error("hreadyout low");
    resp_okay_a: assert property (!hresp)
        else $error("hresp not okay");
    report_logged_a: assert property ((report_fatal || report_nonfatal) |-> log_strobe)
        else $error("report without log");
    log_cause_a: assert property (log_strobe |->
        ($past(err_event, 3) | $past(err_event, 5) | $past(err_event, 7)) != 32'h0)
        else $error("log without event");
    reset_quiet_a: assert property ($rose(rst_n) |-> !irq && !log_strobe && !report_fatal
        && !report_nonfatal && first_err_ptr == 5'h0)
        else $error("outputs not cleared by reset");
    hot_irq_a: assert property (!hot_rst_n ##1 !hot_rst_n |=> !irq)
        else $error("irq survives hot reset");
    hot_ptr_a: assert property (!hot_rst_n |=> first_err_ptr == 5'h0)
        else $error("pointer survives hot reset");
    rdata_hold_a: assert property (hot_rst_n && !(hsel && hready && htrans[1] && !hwrite)
        |=> $stable(hrdata))
        else $error("hrdata changed without read");
endmodule // aer_props
bind aer_uncorr_mask_sev aer_props aer_props_i (.clk, .rst_n, .hot_rst_n, .hsel, .htrans,
    .hwrite, .hready, .hrdata, .hreadyout, .hresp, .err_event, .log_strobe, .first_err_ptr,
    .report_fatal, .report_nonfatal, .irq);

// ### dv/tb_top.sv
// Self-checking bench for the uncorrectable mask and severity block
`timescale 1ns/1ps
`include "aer_defs.vh"
module tb_top;
    logic clk = 0, rst_n = 0, hot_rst_n = 1, hsel = 0, hwrite = 0, lg, ft, nf;
    logic [11:0] haddr = 12'h0;
    logic [1:0] htrans = 2'h0;
    logic [2:0] hsize = 3'h2;
    logic [31:0] hwdata = 32'h0, err_event = 32'h0, hrdata, q;
    logic hreadyout, hresp, log_strobe, report_fatal, report_nonfatal, irq;
    logic [4:0] first_err_ptr;
    int n_errors = 0, comparisons = 0;
    always #5 clk = ~clk;
    aer_uncorr_mask_sev aer_uncorr_mask_sev_i (.clk(clk), .rst_n(rst_n), .hot_rst_n(hot_rst_n),
        .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
        .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout),
        .hresp(hresp), .err_event(err_event), .log_strobe(log_strobe),
        .first_err_ptr(first_err_ptr), .report_fatal(report_fatal),
        .report_nonfatal(report_nonfatal), .irq(irq));
    task results;
        $display("Errors %0d of %0d comparisons", n_errors, comparisons);
        if (n_errors == 0 && comparisons > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask
    task chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp) begin
            $display("MISMATCH %s expected %h seen %h", nm, exp, got);
            n_errors++;
        end
    endtask
    task automatic bus(input logic [11:0] a, input logic w, input logic [31:0] d);
        int n;
        @(posedge clk);
        hsel <= 1;
        haddr <= a;
        htrans <= 2'h2;
        hwrite <= w;
        n = 0;
        do begin @(posedge clk); n++; end while (hreadyout !== 1'b1 && n < 20);
        hsel <= 0;
        htrans <= 2'h0;
        hwdata <= d;
        do begin @(posedge clk); n++; end while (hreadyout !== 1'b1 && n < 40);
        q = hrdata;
        if (hreadyout !== 1'b1) begin
            n_errors++;
            results;
        end
    endtask
    // Holds one event and gathers the pulses it causes
    task ev(input int b);
        @(posedge clk);
        err_event <= 32'h1 << b;
        {lg, ft, nf} = 3'b000;
        repeat (10) begin
            @(posedge clk);
            {lg, ft, nf} = {lg | log_strobe, ft | report_fatal, nf | report_nonfatal};
        end
        err_event <= 32'h0;
        repeat (6) @(posedge clk);
    endtask
    task reset_values;
        bus(`SEV_OFFSET, 0, 0); chk("severity", q, 32'h0000_2030);
        bus(`MASK_OFFSET, 0, 0); chk("mask", q, 32'h0040_0000);
        bus(12'h300, 1, 32'hffff_ffff); bus(12'h300, 0, 0); chk("unmapped", q, 0);
        bus(`SEV_OFFSET, 1, 32'hffff_ffff); bus(`SEV_OFFSET, 0, 0);
        chk("severity ones", q, 32'h0000_3031);
        bus(`SEV_OFFSET, 1, 0); bus(`SEV_OFFSET, 0, 0); chk("severity zero", q, 0);
        bus(`SEV_OFFSET, 1, 32'h0000_2030);
    endtask
    task mask_gating;
        bus(`CTRL_OFFSET, 1, 0); bus(`MASK_OFFSET, 0, 0); chk("ie gated", q, 0);
        bus(`MASK_OFFSET, 1, 32'hff80_0000); bus(`CTRL_OFFSET, 1, 1);
        bus(`MASK_OFFSET, 0, 0); chk("ie kept", q, 32'h00c0_0000);
        bus(`CTRL_OFFSET, 1, 3); bus(`MASK_OFFSET, 0, 0); chk("mc gated", q, 32'h0040_0000);
        bus(`MASK_OFFSET, 1, 0); bus(`CTRL_OFFSET, 1, 1);
        bus(`MASK_OFFSET, 0, 0); chk("mc kept", q, 32'h0080_0000);
        bus(`MASK_OFFSET, 1, 32'h0040_0000);
    endtask
    task events;
        bus(`INT_MASK_OFFSET, 1, 7);
        ev(22); chk("masked log", {lg, ft, nf}, 0);
        bus(`STATUS_OFFSET, 0, 0); chk("status kept", q, 32'h0040_0000);
        bus(`STATUS_OFFSET, 1, 32'hffff_ffff);
        ev(4); chk("fatal", {lg, ft, nf}, 3'b110);
        chk("pointer", first_err_ptr, 4);
        chk("irq set", irq, 1);
        bus(`INT_MASK_OFFSET, 1, 0); repeat (2) @(posedge clk); chk("irq masked", irq, 0);
        bus(`STATUS_OFFSET, 1, 32'hffff_ffff); bus(`INT_STATUS_OFFSET, 1, 7);
        ev(12); chk("nonfatal", {lg, ft, nf}, 3'b101);
        bus(`STATUS_OFFSET, 1, 32'hffff_ffff);
        bus(`SEV_OFFSET, 1, 32'h0000_2031);
        ev(0); chk("unused bit", {lg, ft, nf}, 3'b100);
        bus(`SEV_OFFSET, 1, 32'h0000_2010); bus(`STATUS_OFFSET, 1, 32'hffff_ffff);
    endtask
    task hot_reset;
        ev(13); chk("flow fatal", {lg, ft, nf}, 3'b110);
        @(posedge clk); hot_rst_n <= 0;
        repeat (2) @(posedge clk); hot_rst_n <= 1;
        bus(`SEV_OFFSET, 0, 0); chk("sev sticky", q, 32'h0000_2010);
        bus(`STATUS_OFFSET, 0, 0); chk("status cleared", q, 0);
        ev(5); chk("surprise nonfatal", {lg, ft, nf}, 3'b101);
    endtask
    initial begin
        repeat (5) @(posedge clk);
        rst_n <= 1;
        reset_values;
        mask_gating;
        events;
        hot_reset;
        results;
    end
endmodule // tb_top
